// ---- fapc_map.svh ----
// Register offsets, field positions, reset values and timing figures of the alert and fault block.
// Assumes an eight-bit register port already decoded by the device's control interface.
`ifndef FAPC_MAP_SVH
`define FAPC_MAP_SVH
// Register offsets.
`define FAPC_ADDR_ALERT_CFG   8'h42
`define FAPC_ADDR_FAULT_CFG   8'h43
`define FAPC_ADDR_TUNE_CFG    8'h4f
// Reset values.
`define FAPC_RST_ALERT_CFG    8'h00
`define FAPC_RST_FAULT_CFG    8'h50
`define FAPC_RST_TUNE_CFG     8'h00
// Alert configuration fields.
`define FAPC_POL_BIT          7
`define FAPC_EVT_HI           6
`define FAPC_EVT_LO           5
`define FAPC_INPD_HI          4
`define FAPC_INPD_LO          3
`define FAPC_RDBK_BIT         2
`define FAPC_INRCV_BIT        1
`define FAPC_CLR_BIT          0
// Converter fault configuration fields.
`define FAPC_OUTPD_HI         6
`define FAPC_OUTPD_LO         5
`define FAPC_OUTRCV_BIT       4
`define FAPC_OUTSTS_BIT       3
`define FAPC_SKIPPU_BIT       2
`define FAPC_DETDIS_BIT       1
`define FAPC_REGDIS_BIT       0
// Writable bits of the two mixed registers.
`define FAPC_FAULT_WMASK      8'h77
`define FAPC_TUNE_WMASK       8'hfe
// Power tuning fields.
`define FAPC_MODHALF_BIT      7
`define FAPC_BYPASS_BIT       5
`define FAPC_LPFILT_BIT       2
`define FAPC_IREF_BIT         1
// Alert pulse timing.
`define FAPC_CLK_KHZ          10000
`define FAPC_PULSE_US         2000
`define FAPC_PERIOD_US        4000
`endif

// ---- fapc_pkg.sv ----
// Types shared by the alert and fault block and its surroundings.
// Assumes fapc_map.svh is on the include path.
package fapc_pkg;
	// One access from the control interface, valid for one cycle.
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} fapc_reg_req_t;

	// Static controls handed to the converter datapath.
	typedef struct packed {
		logic modulator_clock_half;
		logic fir_segmenter_bypass;
		logic reduced_power_filter_en;
		logic reference_current_sel;
	} fapc_tune_t;

	// Alert styles.
	typedef enum logic [1:0] {
		FAPC_EVT_LATCHED = 2'h0,
		FAPC_EVT_LIVE    = 2'h1,
		FAPC_EVT_REPEAT  = 2'h2,
		FAPC_EVT_ONESHOT = 2'h3
	} fapc_evt_t;

	// Which faults power channels down.
	typedef enum logic [1:0] {
		FAPC_PD_NONE     = 2'h0,
		FAPC_PD_UNMASKED = 2'h1,
		FAPC_PD_ALL      = 2'h2,
		FAPC_PD_RSVD     = 2'h3
	} fapc_pdsel_t;

	// Alert pulse sequencer.
	typedef enum logic [2:0] {
		FAPC_ST_IDLE = 3'h1,
		FAPC_ST_ON   = 3'h2,
		FAPC_ST_OFF  = 3'h4
	} fapc_state_t;
endpackage : fapc_pkg

// ---- fapc_top.sv ----
// Alert pin, fault power-down and recovery, and converter power tuning controls.
// Assumes register accesses and interrupt sources are synchronous to core_clk.
//
// Notes on behaviour
// RULE1: Alert pin polarity bit 7: zero active low, one active high.
// RULE2: Style 0 asserts alert while any unmasked latched flag is set.
// RULE3: Style 1 asserts alert while any unmasked live condition is present.
// RULE4: Style 2 pulses alert 2 ms every 4 ms while unmasked latches remain.
// RULE5: Style 3 gives one 2 ms pulse per unmasked interrupt event; code merges same-cycle events and holds over at most one event per pulse.
// RULE6: Bits 4-3 pick input faults causing power-down: none, unmasked, all.
// RULE7: Readback bit 2 set shows only unmasked flags in the latched view.
// RULE8: Bit 1 picks automatic or manual recovery of faulted input channels.
// RULE9: Clear-on-read bit 0 set clears flags on read even while live.
// RULE10: Output power-down select at bits 6-5 resets to all faults.
// RULE11: Output recovery bit resets to manual; zero gives automatic recovery.
// RULE12: Status bit 3 reads one while any output channel is held down.
// RULE13: Bit 2 set ignores guard faults during converter power-up.
// RULE14: Bit 1 set disables output guard and short fault detection.
// RULE15: Bit 0 set disables regulator short detection.
// RULE16: Power tuning bit 7 halves the modulator clock to 1.5 MHz.
// RULE17: Power tuning bit 5 bypasses the FIR filter and segmenter.
// RULE18: Power tuning bit 2 enables the reduced-power interpolation filter.
// RULE19: Power tuning bit 1 selects reference current Vref/R or Vref/2R.
// RULE20: Software writes only reset values into reserved fields.
// RULE21: Latched styles release alert once all unmasked latches are cleared.
`timescale 1ns/1ps
`include "fapc_map.svh"
module fapc_top #(
	parameter int NI         = 4,
	parameter int NO         = 2,
	parameter int NINT       = 8,
	parameter int PULSE_CYC  = `FAPC_PULSE_US * `FAPC_CLK_KHZ / 1000,
	parameter int PERIOD_CYC = `FAPC_PERIOD_US * `FAPC_CLK_KHZ / 1000
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire fapc_pkg::fapc_reg_req_t reg_req,
	output logic [7:0]                  reg_rdata,
	input  wire logic [NINT-1:0]        int_live,
	input  wire logic [NINT-1:0]        int_mask,
	input  wire logic                   latch_rd,
	output logic [NINT-1:0]             latch_rdata,
	output logic                        alert_pin,
	input  wire logic [NI-1:0]          in_fault_live,
	input  wire logic [NI-1:0]          in_fault_mask,
	input  wire logic                   in_pd_release,
	output logic [NI-1:0]               in_pd,
	input  wire logic [NO-1:0]          out_short_live,
	input  wire logic [NO-1:0]          out_guard_live,
	input  wire logic [NO-1:0]          out_fault_mask,
	input  wire logic                   dac_powering_up,
	input  wire logic                   out_pd_release,
	output logic [NO-1:0]               out_pd,
	input  wire logic                   regulator_short_live,
	output logic                        regulator_short_flag,
	output fapc_pkg::fapc_tune_t        tune
);
	import fapc_pkg::*;

	localparam int CW = $clog2(PERIOD_CYC + 1);
	localparam logic [CW-1:0] ON_LAST  = CW'(PULSE_CYC - 1);
	localparam logic [CW-1:0] OFF_LAST = CW'(PERIOD_CYC - PULSE_CYC - 1);

	typedef struct packed {
		logic [7:0]      alert_cfg;
		logic [7:0]      fault_cfg;
		logic [7:0]      tune_cfg;
		logic [NINT-1:0] latch;
		logic [NINT-1:0] live_q;
		logic [NINT-1:0] lrd;
		logic [NI-1:0]   in_pd;
		logic [NO-1:0]   out_pd;
		logic            reg_short;
		fapc_state_t     st;
		logic [CW-1:0]   cnt;
		logic            pending;
		logic            alert;
		logic [7:0]      rdata;
	} fapc_regs_t;

	////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops; assertion stays asynchronous.
	logic rst_meta_r;
	logic rst_sync_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Picks the faults that count for power-down under a select value.
	function automatic logic [7:0] fapc_pick(input logic [1:0] sel, input logic [7:0] live,
			input logic [7:0] mask);
		case (sel)
			FAPC_PD_UNMASKED: fapc_pick = live & ~mask;
			FAPC_PD_ALL:      fapc_pick = live;
			default:          fapc_pick = 8'h00;
		endcase
	endfunction : fapc_pick

	////////////////////////////////////////////////////////////////////////////
	fapc_regs_t s_r;
	fapc_regs_t s_nxt;
	fapc_evt_t  evt;
	logic [NINT-1:0] rise;
	logic [NINT-1:0] clr;
	logic [NO-1:0]   out_fault;
	logic [NI-1:0]   in_hit;
	logic [NO-1:0]   out_hit;
	logic            any_latched;
	logic            any_live;
	logic            new_event;
	logic            active;

	// Event decode: a flag latches on the rising edge of its live condition.
	always_comb begin
		evt         = fapc_evt_t'(s_r.alert_cfg[`FAPC_EVT_HI:`FAPC_EVT_LO]);
		rise        = int_live & ~s_r.live_q;
		any_latched = |(s_r.latch & ~int_mask);
		any_live    = |(int_live & ~int_mask);                              // see RULE3
		new_event   = |(rise & ~int_mask);
		// Read clears only settled flags unless clearing is forced.
		clr = {NINT{latch_rd}} & (s_r.alert_cfg[`FAPC_CLR_BIT] ? {NINT{1'b1}} : ~int_live); // see RULE9
		// Detection gating and the power-up guard exemption.
		out_fault = (out_short_live | (out_guard_live &
			~{NO{dac_powering_up & s_r.fault_cfg[`FAPC_SKIPPU_BIT]}}))      // see RULE13
			& ~{NO{s_r.fault_cfg[`FAPC_DETDIS_BIT]}};                       // see RULE14
		in_hit  = NI'(fapc_pick(s_r.alert_cfg[`FAPC_INPD_HI:`FAPC_INPD_LO],
			8'(in_fault_live), 8'(in_fault_mask)));                         // see RULE6
		out_hit = NO'(fapc_pick(s_r.fault_cfg[`FAPC_OUTPD_HI:`FAPC_OUTPD_LO],
			8'(out_fault), 8'(out_fault_mask)));                            // see RULE10
	end

	// Next state of the whole block.
	always_comb begin
		s_nxt        = s_r;
		s_nxt.live_q = int_live;
		// A new event in the clearing cycle survives because set comes last.
		s_nxt.latch  = (s_r.latch & ~clr) | rise;                           // see RULE9
		s_nxt.lrd    = s_r.alert_cfg[`FAPC_RDBK_BIT] ? (s_r.latch & ~int_mask) : s_r.latch; // see RULE7

		// Held channels release when the fault is gone, on their own or by software.
		s_nxt.in_pd = s_r.in_pd & ~(~in_fault_live &
			{NI{~s_r.alert_cfg[`FAPC_INRCV_BIT] | in_pd_release}}) | in_hit; // see RULE8
		s_nxt.out_pd = s_r.out_pd & ~(~out_fault &
			{NO{~s_r.fault_cfg[`FAPC_OUTRCV_BIT] | out_pd_release}}) | out_hit; // see RULE11
		s_nxt.reg_short = regulator_short_live & ~s_r.fault_cfg[`FAPC_REGDIS_BIT]; // see RULE15

		// Register writes; read-only and reserved-read bits keep their value.
		if (reg_req.wr) begin
			case (reg_req.addr)
				`FAPC_ADDR_ALERT_CFG: s_nxt.alert_cfg = reg_req.wdata;
				`FAPC_ADDR_FAULT_CFG: s_nxt.fault_cfg = reg_req.wdata & `FAPC_FAULT_WMASK;
				`FAPC_ADDR_TUNE_CFG:  s_nxt.tune_cfg  = reg_req.wdata & `FAPC_TUNE_WMASK;
				default: ;
			endcase
		end
		// Register reads answer one cycle later; unmapped addresses read zero.
		if (reg_req.rd) begin
			case (reg_req.addr)
				`FAPC_ADDR_ALERT_CFG: s_nxt.rdata = s_r.alert_cfg;
				`FAPC_ADDR_FAULT_CFG: s_nxt.rdata = s_r.fault_cfg
					| (8'(|s_r.out_pd) << `FAPC_OUTSTS_BIT);                // see RULE12
				`FAPC_ADDR_TUNE_CFG:  s_nxt.rdata = s_r.tune_cfg;
				default:              s_nxt.rdata = 8'h00;
			endcase
		end

		// Pulse sequencer for the repeating and one-shot styles.
		s_nxt.cnt = s_r.cnt + CW'(1);
		if (new_event && evt == FAPC_EVT_ONESHOT && s_r.st == FAPC_ST_ON) begin
			s_nxt.pending = 1'b1;
		end
		case (s_r.st)
			FAPC_ST_IDLE: begin
				s_nxt.cnt = '0;
				if (evt == FAPC_EVT_REPEAT && any_latched) begin
					s_nxt.st = FAPC_ST_ON;                                  // see RULE4
				end else if (evt == FAPC_EVT_ONESHOT && (new_event || s_r.pending)) begin
					s_nxt.st      = FAPC_ST_ON;                             // see RULE5
					s_nxt.pending = 1'b0;
				end
			end
			FAPC_ST_ON: begin
				if (evt == FAPC_EVT_REPEAT && !any_latched) begin
					s_nxt.st = FAPC_ST_IDLE;                                // see RULE21
				end else if (s_r.cnt == ON_LAST) begin
					s_nxt.cnt = '0;
					s_nxt.st  = (evt == FAPC_EVT_REPEAT) ? FAPC_ST_OFF : FAPC_ST_IDLE;
				end
			end
			FAPC_ST_OFF: begin
				if (!any_latched || evt != FAPC_EVT_REPEAT) begin
					s_nxt.st = FAPC_ST_IDLE;                                // see RULE21
				end else if (s_r.cnt == OFF_LAST) begin
					s_nxt.cnt = '0;
					s_nxt.st  = FAPC_ST_ON;                                 // see RULE4
				end
			end
			default: s_nxt.st = FAPC_ST_IDLE;
		endcase
		if (evt == FAPC_EVT_LATCHED || evt == FAPC_EVT_LIVE) begin
			s_nxt.st      = FAPC_ST_IDLE;
			s_nxt.pending = 1'b0;
		end

		// Alert request by style, then polarity for the pin level.
		case (evt)
			FAPC_EVT_LATCHED: active = any_latched;                         // see RULE2
			FAPC_EVT_LIVE:    active = any_live;                            // see RULE3
			default:          active = (s_r.st == FAPC_ST_ON);
		endcase
		s_nxt.alert = s_r.alert_cfg[`FAPC_POL_BIT] ? active : ~active;      // see RULE1
	end

	// One register stage holds all state; the idle pin level is high after reset.
	always_ff @(posedge core_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			s_r           <= '0;
			s_r.alert_cfg <= `FAPC_RST_ALERT_CFG;
			s_r.fault_cfg <= `FAPC_RST_FAULT_CFG;
			s_r.tune_cfg  <= `FAPC_RST_TUNE_CFG;
			s_r.st        <= FAPC_ST_IDLE;
			s_r.alert     <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from state; tuning bits are static datapath controls.
	assign reg_rdata            = s_r.rdata;
	assign latch_rdata          = s_r.lrd;
	assign alert_pin            = s_r.alert;
	assign in_pd                = s_r.in_pd;
	assign out_pd               = s_r.out_pd;
	assign regulator_short_flag = s_r.reg_short;
	assign tune.modulator_clock_half    = s_r.tune_cfg[`FAPC_MODHALF_BIT]; // see RULE16
	assign tune.fir_segmenter_bypass    = s_r.tune_cfg[`FAPC_BYPASS_BIT];  // see RULE17
	assign tune.reduced_power_filter_en = s_r.tune_cfg[`FAPC_LPFILT_BIT];  // see RULE18
	assign tune.reference_current_sel   = s_r.tune_cfg[`FAPC_IREF_BIT];    // see RULE19

	////////////////////////////////////////////////////////////////////////////
	// Checks on the pin, the flags and the power-down state.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_r);

	latched_level_a: assert property ((evt == FAPC_EVT_LATCHED && $stable(s_r.alert_cfg))
		|=> alert_pin == ($past(s_r.alert_cfg[`FAPC_POL_BIT]) ~^ $past(any_latched))) // see RULE2
		else $error("Latched style alert level wrong.");
	live_level_a: assert property ((evt == FAPC_EVT_LIVE && $stable(s_r.alert_cfg))
		|=> alert_pin == ($past(s_r.alert_cfg[`FAPC_POL_BIT]) ~^ $past(any_live))) // see RULE3
		else $error("Live style alert level wrong.");
	pulse_width_a: assert property (s_r.st == FAPC_ST_ON |-> s_r.cnt <= ON_LAST) // see RULE5
		else $error("Alert pulse overran its width.");
	repeat_gap_a: assert property (s_r.st == FAPC_ST_OFF |-> s_r.cnt <= OFF_LAST) // see RULE4
		else $error("Alert off phase overran.");
	repeat_release_a: assert property ((evt == FAPC_EVT_REPEAT && !any_latched
		&& $stable(evt)) |=> s_r.st == FAPC_ST_IDLE)                     // see RULE21
		else $error("Repeating alert kept running with no flag.");
	flag_keep_a: assert property ((latch_rd && !s_r.alert_cfg[`FAPC_CLR_BIT])
		|=> ~|($past(s_r.latch) & $past(int_live) & ~s_r.latch))        // see RULE9
		else $error("Read cleared a flag whose condition is live.");
	status_bit_a: assert property (reg_req.rd && reg_req.addr == `FAPC_ADDR_FAULT_CFG
		|=> reg_rdata[`FAPC_OUTSTS_BIT] == $past(|s_r.out_pd))          // see RULE12
		else $error("Output hold status wrong.");
	regulator_gate_a: assert property (s_r.fault_cfg[`FAPC_REGDIS_BIT]
		|=> !regulator_short_flag)                                       // see RULE15
		else $error("Regulator short flagged while disabled.");
	out_hold_a: assert property (s_r.fault_cfg[`FAPC_OUTRCV_BIT] && !out_pd_release
		&& $stable(s_r.fault_cfg) |=> (out_pd & $past(out_pd)) == $past(out_pd)) // see RULE11
		else $error("Output channel recovered under manual recovery.");

	oneshot_c: cover property (evt == FAPC_EVT_ONESHOT && s_r.st == FAPC_ST_ON && new_event);
	repeat_c:  cover property (s_r.st == FAPC_ST_OFF ##1 s_r.st == FAPC_ST_ON);
	outpd_c:   cover property (|out_pd ##1 ~|out_pd);
endmodule : fapc_top

// ---- fapc_host.sv ----
// Host model for the alert and fault block: register accesses, latched reads, alert watch.
// Assumes one access per request cycle and registered read data one cycle later.
`timescale 1ns/1ps
`include "fapc_map.svh"
module fapc_host (
	input  wire logic             core_clk,
	input  wire logic             alert_pin,
	output fapc_pkg::fapc_reg_req_t reg_req,
	input  wire logic [7:0]       reg_rdata,
	output logic                  latch_rd,
	output logic                  alert_on
);
	import fapc_pkg::*;
	logic pol_r;

	// The host knows the polarity it programmed, so alert_on is the logical alert.
	assign alert_on = (alert_pin === pol_r);

	initial begin
		reg_req = '0;
		latch_rd = 1'b0;
		pol_r = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reserved fields are forced to their reset values so software never disturbs them.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] m;
		m = (a == `FAPC_ADDR_TUNE_CFG) ? 8'ha6 :
			(a == `FAPC_ADDR_FAULT_CFG) ? `FAPC_FAULT_WMASK : 8'hff;
		@(posedge core_clk);
		#1;
		reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d & m};
		@(posedge core_clk);
		#1;
		reg_req = '0;
		if (a == `FAPC_ADDR_ALERT_CFG) pol_r = d[`FAPC_POL_BIT];
	endtask : wr

	// Read data is taken the cycle after the request edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge core_clk);
		#1;
		reg_req = '0;
		d = reg_rdata;
	endtask : rd

	// One read of the latched flag register.
	task automatic lrd();
		@(posedge core_clk);
		#1;
		latch_rd = 1'b1;
		@(posedge core_clk);
		#1;
		latch_rd = 1'b0;
	endtask : lrd
endmodule : fapc_host

// ---- fapc_top_tb.sv ----
// Self-checking bench for the alert and fault block with shortened alert pulse timing.
// Assumes fapc_host drives the register port and latched reads.
`timescale 1ns/1ps
module fapc_top_tb;
	import fapc_pkg::*;
	logic core_clk, rst_n, latch_rd, alert_pin, alert_on;
	logic in_pd_release, out_pd_release, dac_powering_up, reg_sh, reg_fl;
	logic [7:0] int_live, int_mask, reg_rdata, latch_rdata, d;
	logic [3:0] in_fault_live, in_fault_mask, in_pd;
	logic [1:0] out_short_live, out_guard_live, out_fault_mask, out_pd;
	fapc_reg_req_t reg_req;
	fapc_tune_t tune;
	int fail_count, comparisons, cyc, c;

	fapc_top #(.PULSE_CYC(4), .PERIOD_CYC(8)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .int_live(int_live), .int_mask(int_mask),
		.latch_rd(latch_rd), .latch_rdata(latch_rdata), .alert_pin(alert_pin),
		.in_fault_live(in_fault_live), .in_fault_mask(in_fault_mask),
		.in_pd_release(in_pd_release), .in_pd(in_pd), .out_short_live(out_short_live),
		.out_guard_live(out_guard_live), .out_fault_mask(out_fault_mask),
		.dac_powering_up(dac_powering_up), .out_pd_release(out_pd_release), .out_pd(out_pd),
		.regulator_short_live(reg_sh), .regulator_short_flag(reg_fl), .tune(tune));
	fapc_host h (.core_clk(core_clk), .alert_pin(alert_pin), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .latch_rd(latch_rd), .alert_on(alert_on));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and a cycle ceiling well above the two hundred or so cycles the tests need.
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Inputs change a fixed 1 ns after the rising edge.
	task automatic st(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : st

	// Counts cycles of logical alert over a window.
	task automatic cnt(input int n);
		c = 0;
		repeat (n) begin
			st(1);
			c += int'(alert_on);
		end
	endtask : cnt

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, in_pd_release, out_pd_release, dac_powering_up, reg_sh} = '0;
		{int_live, int_mask, in_fault_live, in_fault_mask} = '0;
		{out_short_live, out_guard_live, out_fault_mask} = '0;
		st(4);
		rst_n = 1'b1;
		st(3);
		chk("idle pin", 8'h01, {7'h0, alert_pin});
		h.rd(8'h42, d); chk("alert_config", 8'h00, d);
		h.rd(8'h43, d); chk("converter_fault_config", 8'h50, d);
		h.rd(8'h44, d); chk("unmapped", 8'h00, d);
		h.wr(8'h4f, 8'hff); h.rd(8'h4f, d); chk("power_tuning_config", 8'ha6, d);
		chk("tune", 8'h0f, {4'h0, tune});
		// Latched style: flag holds the alert until a read clears it.
		int_live = 8'h01; st(1); int_live = 8'h00; st(3);
		chk("latched alert", 8'h01, {7'h0, alert_on});
		h.lrd(); st(2); chk("released alert", 8'h00, {7'h0, alert_on});
		int_live = 8'h02; st(3); h.lrd(); st(2);
		chk("live flag kept", 8'h02, latch_rdata);
		h.wr(8'h42, 8'h01); h.lrd(); st(2); chk("forced clear", 8'h00, latch_rdata);
		int_mask = 8'h04; int_live = 8'h04; st(1); int_live = 8'h00; st(3);
		chk("masked shown", 8'h04, latch_rdata);
		chk("masked no alert", 8'h00, {7'h0, alert_on});
		h.wr(8'h42, 8'h05); st(2); chk("masked hidden", 8'h00, latch_rdata);
		h.lrd(); int_mask = 8'h00;
		// Live style with the pin active high.
		h.wr(8'h42, 8'ha0); st(2); chk("high idle", 8'h00, {7'h0, alert_pin});
		int_live = 8'h08; st(2); chk("live on", 8'h01, {7'h0, alert_pin});
		int_live = 8'h00; st(2); chk("live off", 8'h00, {7'h0, alert_pin});
		// Repeating style: four of every eight cycles while a flag stays set.
		h.wr(8'h42, 8'h40); h.lrd(); int_live = 8'h01; st(1); int_live = 8'h00; st(4);
		cnt(16); chk("repeat on", 8'h08, 8'(c));
		h.lrd(); st(3); cnt(10); chk("repeat stop", 8'h00, 8'(c));
		// One-shot style: one pulse per event.
		h.wr(8'h42, 8'h60); int_live = 8'h02; st(1); int_live = 8'h00;
		cnt(20); chk("one shot", 8'h04, 8'(c));
		// A second event during a pulse is held over and gives a second pulse.
		int_live = 8'h04; st(1); int_live = 8'h00; cnt(2); d = 8'(c);
		int_live = 8'h08; cnt(1); d += 8'(c); int_live = 8'h00;
		cnt(20); chk("one shot pending", 8'h08, d + 8'(c));
		h.lrd();
		// Input power-down: unmasked only with auto recovery, then all with manual recovery.
		h.wr(8'h42, 8'h08); in_fault_mask = 4'h1; in_fault_live = 4'h3; st(2);
		chk("in unmasked", 8'h02, {4'h0, in_pd});
		in_fault_live = 4'h0; st(2); chk("in auto", 8'h00, {4'h0, in_pd});
		h.wr(8'h42, 8'h12); in_fault_live = 4'h1; st(2);
		chk("in all", 8'h01, {4'h0, in_pd});
		in_fault_live = 4'h0; st(2); chk("in held", 8'h01, {4'h0, in_pd});
		in_pd_release = 1'b1; st(1); in_pd_release = 1'b0; st(1);
		chk("in released", 8'h00, {4'h0, in_pd});
		// Output power-down at reset settings (all faults, manual recovery), then guard skip, detection, select and regulator controls.
		out_fault_mask = 2'h1; out_short_live = 2'h1; st(2);
		chk("out all", 8'h01, {6'h0, out_pd});
		h.rd(8'h43, d); chk("out status", 8'h58, d);
		out_short_live = 2'h0; st(2); chk("out held", 8'h01, {6'h0, out_pd});
		out_pd_release = 1'b1; st(1); out_pd_release = 1'b0; st(1);
		h.rd(8'h43, d); chk("out status clear", 8'h50, d);
		h.wr(8'h43, 8'h44); dac_powering_up = 1'b1; out_guard_live = 2'h2; st(2);
		chk("guard skipped", 8'h00, {6'h0, out_pd});
		dac_powering_up = 1'b0; st(2); chk("guard down", 8'h02, {6'h0, out_pd});
		out_guard_live = 2'h0; st(2); chk("out auto", 8'h00, {6'h0, out_pd});
		h.wr(8'h43, 8'h46); out_short_live = 2'h3; st(2);
		chk("detect off", 8'h00, {6'h0, out_pd});
		h.wr(8'h43, 8'h20); st(2); chk("out unmasked", 8'h02, {6'h0, out_pd});
		out_short_live = 2'h0; reg_sh = 1'b1; st(2);
		chk("reg short", 8'h01, {7'h0, reg_fl});
		h.wr(8'h43, 8'h21); st(1); chk("reg short off", 8'h00, {7'h0, reg_fl});
		h.wr(8'h43, 8'h01); out_short_live = 2'h3; st(2);
		chk("out none", 8'h00, {6'h0, out_pd});
		report_and_stop();
	end
endmodule : fapc_top_tb
